// ### rtl/sfc_pkg.sv
/*
 * sfc_pkg: constants and carrier types for the serial flash command block.
 * assumes one 125 MHz system clock; serial pins sampled from outside.
 */
package sfc_pkg;
  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_ARM_WRITE   = 8'h06;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WIPE_32K    = 8'h52;
  localparam logic [7:0] OP_WIPE_64K    = 8'hd8;
  localparam logic [7:0] OP_ARRAY_A     = 8'h60;
  localparam logic [7:0] OP_ARRAY_B     = 8'hc7;
  localparam logic [7:0] OP_SLEEP       = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID     = 8'hab;
  localparam logic [7:0] OP_MAKER_PART  = 8'h90;
  localparam logic [7:0] OP_THREE_ID    = 8'h9f;
  // ==========================================================
  // identity values, arbitrary
  localparam logic [7:0] MAKER_ID    = 8'h5a;
  localparam logic [7:0] PART_ID     = 8'h11;
  localparam logic [7:0] MEM_TYPE_ID = 8'h64;
  localparam logic [7:0] CAPACITY_ID = 8'h11;
  // ==========================================================
  // bit counts on the serial link
  localparam logic [5:0] BITS_OP      = 6'h08;
  localparam logic [5:0] BITS_OP_ADDR = 6'h20;
  // ==========================================================
  // status layout
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  // ==========================================================
  // timing, in microseconds, and cycles at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int BLOCK_WIPE_US = 100;
  localparam int ARRAY_WIPE_US = 400;
  localparam int SLEEP_ENTRY_US = 3;
  localparam int WAKE_SHORT_US = 3;
  localparam int WAKE_LONG_US = 5;
  localparam int BLOCK_WIPE_CYC = BLOCK_WIPE_US * CLK_MHZ;
  localparam int ARRAY_WIPE_CYC = ARRAY_WIPE_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
  localparam int WAKE_SHORT_CYC = WAKE_SHORT_US * CLK_MHZ;
  localparam int WAKE_LONG_CYC = WAKE_LONG_US * CLK_MHZ;
  // ==========================================================
  // carrier types
  typedef struct packed {
    logic protect_level_hi;
    logic protect_level_mid;
    logic protect_level_lo;
  } sfc_protect_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;   // 0 block32, 1 block64, 2 array
    logic [23:0] addr;
  } sfc_wipe_t;
endpackage

// ### rtl/sfc_core.sv
/*
 * sfc_core: command decoder for wipe, sleep and identification commands.
 * assumes the serial pins come asynchronous to clk and the array engine
 * takes wipe requests as a one-cycle pulse.
 */
// Contract
// R01: 52h erases enclosing 32 KB block
// R02: D8h erases enclosing 64 KB block
// R03: no erase unless write latch armed
// R04: block erase needs select rise after 32 bits
// R05: select rise starts cycle, busy flag set
// R06: write latch cleared during erase cycle; code clears it as busy ends
// R07: refuse block erase in protected region
// R08: 60h/C7h array erase, rise after 8
// R09: array erase only when protection zero
// R10: B9h enters sleep after entry delay
// R11: while asleep, only ABh accepted
// R12: sleep refused while busy
// R13: sleep cleared by reset, standby after
// R14: ABh wakes, release delay before commands
// R15: ABh plus 3 dummies streams part ID
// R16: host waits longer delay after ID wake
// R17: ABh ignored while busy
// R18: 90h addr 0 gives maker, part
// R19: 90h addr 1 gives part first
// R20: 9Fh gives maker, type, capacity
// R21: 9Fh not decoded while busy
// R22: host avoids 9Fh while asleep
// R23: input bits captured on rising edges
// R24: 05h returns status byte
// R25: select rise ends ID output
// R26: erased range reads all ones
// R27: forbidden opcodes dropped until select rises
`timescale 1ns/1ps
module sfc_core (
  // system
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // serial link
  input  wire logic                 sel_b,
  input  wire logic                 sclk,
  input  wire logic                 sdi,
  output logic                      sdo,
  output logic                      sdo_oe,
  // configuration and status
  input  wire sfc_pkg::sfc_protect_t protect,
  input  wire logic                 arm_write_cmd,
  output logic                      write_in_progress,
  output logic                      write_latch_armed,
  output logic                      asleep,
  // array engine
  output sfc_pkg::sfc_wipe_t        wipe_req
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // synchronisers and edges
  logic [1:0] sel_s_q, sclk_s_q, sdi_s_q;
  logic       sel_p_q, sclk_p_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_s_q  <= 2'h3;
      sclk_s_q <= 2'h0;
      sdi_s_q  <= 2'h0;
      sel_p_q  <= 1'b1;
      sclk_p_q <= 1'b0;
    end else begin
      sel_s_q  <= {sel_s_q[0], sel_b};
      sclk_s_q <= {sclk_s_q[0], sclk};
      sdi_s_q  <= {sdi_s_q[0], sdi};
      sel_p_q  <= sel_s_q[1];
      sclk_p_q <= sclk_s_q[1];
    end
  end
  wire sel_lo   = !sel_s_q[1];
  wire sel_rise = sel_s_q[1] && !sel_p_q;
  wire sck_rise = sel_lo && sclk_s_q[1] && !sclk_p_q;
  wire sck_fall = sel_lo && !sclk_s_q[1] && sclk_p_q;

  // ==========================================================
  // shift in
  logic [31:0] sh_q;
  logic [5:0]  cnt_q;
  logic        drop_q;
  logic [7:0]  op_q;
  wire  [31:0] sh_d  = {sh_q[30:0], sdi_s_q[1]};
  wire  [5:0]  cnt_d = (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;

  // ==========================================================
  // state
  typedef enum logic [3:0] {
    SFC_IDLE  = 4'b0001,
    SFC_BUSY  = 4'b0010,
    SFC_SLEEP = 4'b0100,
    SFC_WAIT  = 4'b1000
  } sfc_state_t;
  sfc_state_t st_q;
  logic [31:0] tmr_q;
  logic        wel_q;
  logic        to_sleep_q;

  wire busy    = (st_q == SFC_BUSY);
  wire sleeping = (st_q == SFC_SLEEP);
  wire [2:0] bp = {protect.protect_level_hi, protect.protect_level_mid,
                   protect.protect_level_lo};
  wire [7:0] status = {3'h0, bp, wel_q, busy};

  // R07 protected region grows down from the top of a 16-block space
  function automatic logic blk_prot(input logic [2:0] lvl,
                                    input logic [23:0] a);
    logic [3:0] blk;
    blk = a[19:16];
    case (lvl)
      3'h0:    blk_prot = 1'b0;
      3'h1:    blk_prot = (blk == 4'hf);
      3'h2:    blk_prot = (blk >= 4'he);
      3'h3:    blk_prot = (blk >= 4'hc);
      3'h4:    blk_prot = (blk >= 4'h8);
      default: blk_prot = 1'b1;
    endcase
  endfunction

  // ==========================================================
  // decode at select rise
  wire is_blk  = (op_q == sfc_pkg::OP_WIPE_32K) ||
                 (op_q == sfc_pkg::OP_WIPE_64K);
  wire is_arr  = (op_q == sfc_pkg::OP_ARRAY_A) ||
                 (op_q == sfc_pkg::OP_ARRAY_B);
  // R03 R04 armed latch, exact length
  wire blk_ok  = is_blk && cnt_q == sfc_pkg::BITS_OP_ADDR && wel_q &&
                 !blk_prot(bp, sh_q[23:0]);
  // R08 R09 array erase, no protection
  wire arr_ok  = is_arr && cnt_q == sfc_pkg::BITS_OP && wel_q &&
                 bp == 3'h0;
  // R12 sleep only when idle and exact length
  wire slp_ok  = op_q == sfc_pkg::OP_SLEEP && cnt_q == sfc_pkg::BITS_OP;
  wire wake_ok = op_q == sfc_pkg::OP_WAKE_ID && cnt_q >= sfc_pkg::BITS_OP;
  wire act     = sel_rise && !drop_q && st_q == SFC_IDLE;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q <= 32'h0;
      cnt_q <= 6'h0;
      op_q <= 8'h0;
      drop_q <= 1'b0;
    end else if (sel_rise) begin
      cnt_q <= 6'h0;
      drop_q <= 1'b0;
    end else if (sck_rise) begin
      // R23 capture on rising sclk
      // address frozen once full: the 90h order bit must outlive output
      if (cnt_q < sfc_pkg::BITS_OP_ADDR)
        sh_q <= sh_d;
      cnt_q <= cnt_d;
      if (cnt_q == 6'h07) begin
        op_q <= sh_d[7:0];
        // R11 R17 R21 R27 forbidden opcodes dropped
        drop_q <= (sleeping && sh_d[7:0] != sfc_pkg::OP_WAKE_ID) ||
                  (busy && sh_d[7:0] != sfc_pkg::OP_READ_STATUS) ||
                  (st_q == SFC_WAIT);
      end
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SFC_IDLE;   // R13 standby after reset
      tmr_q <= 32'h0;
      wel_q <= 1'b0;
      to_sleep_q <= 1'b0;
      wipe_req <= '0;
    end else begin
      wipe_req.valid <= 1'b0;
      if (arm_write_cmd && st_q == SFC_IDLE)
        wel_q <= 1'b1;
      case (st_q)
        SFC_IDLE: begin
          if (act && (blk_ok || arr_ok)) begin
            // R01 R02 R05 R26 start erase, engine fills ones
            st_q <= SFC_BUSY;
            to_sleep_q <= 1'b0;
            wipe_req.valid <= 1'b1;
            wipe_req.kind <= arr_ok ? 2'h2 :
                             (op_q == sfc_pkg::OP_WIPE_32K ? 2'h0 : 2'h1);
            wipe_req.addr <= sh_q[23:0];
            tmr_q <= arr_ok ? 32'(sfc_pkg::ARRAY_WIPE_CYC)
                            : 32'(sfc_pkg::BLOCK_WIPE_CYC);
          end else if (act && slp_ok) begin
            // R10 entry delay then sleep
            st_q <= SFC_WAIT;
            to_sleep_q <= 1'b1;
            tmr_q <= 32'(sfc_pkg::SLEEP_ENTRY_CYC);
          end
        end
        SFC_BUSY: begin
          // R06 latch cleared at end of cycle
          if (tmr_q == 32'h1) begin
            wel_q <= 1'b0;
            st_q <= SFC_IDLE;
          end
          tmr_q <= tmr_q - 32'h1;
        end
        SFC_SLEEP: begin
          // R14 wake, long delay if id read
          if (sel_rise && !drop_q && wake_ok) begin
            st_q <= SFC_WAIT;
            to_sleep_q <= 1'b0;
            tmr_q <= (cnt_q > sfc_pkg::BITS_OP) ?
                     32'(sfc_pkg::WAKE_LONG_CYC) :
                     32'(sfc_pkg::WAKE_SHORT_CYC);
          end
        end
        SFC_WAIT: begin
          if (tmr_q <= 32'h1)
            st_q <= to_sleep_q ? SFC_SLEEP : SFC_IDLE;
          tmr_q <= tmr_q - 32'h1;
        end
        default: st_q <= SFC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // shift out on falling sclk
  wire [5:0] ob = cnt_q - sfc_pkg::BITS_OP;
  wire [5:0] oi = cnt_q - sfc_pkg::BITS_OP_ADDR;
  logic [7:0] obyte;
  logic [2:0] obit;
  logic       oen;
  always_comb begin
    obyte = 8'h0;
    obit = 3'h0;
    oen = 1'b0;
    if (!drop_q && cnt_q >= sfc_pkg::BITS_OP) begin
      case (op_q)
        // R24 status byte repeated
        sfc_pkg::OP_READ_STATUS: begin
          obyte = status; obit = ob[2:0]; oen = 1'b1;
        end
        // R20 maker, type, capacity
        sfc_pkg::OP_THREE_ID: begin
          obit = ob[2:0]; oen = ob < 6'h18;
          obyte = (ob[4:3] == 2'h0) ? sfc_pkg::MAKER_ID :
                  (ob[4:3] == 2'h1) ? sfc_pkg::MEM_TYPE_ID :
                                      sfc_pkg::CAPACITY_ID;
        end
        // R15 part id repeats after dummies
        sfc_pkg::OP_WAKE_ID: begin
          obit = oi[2:0]; oen = cnt_q >= sfc_pkg::BITS_OP_ADDR;
          obyte = sfc_pkg::PART_ID;
        end
        // R18 R19 order by address bit 0
        sfc_pkg::OP_MAKER_PART: begin
          obit = oi[2:0]; oen = cnt_q >= sfc_pkg::BITS_OP_ADDR;
          obyte = (oi[3] ^ sh_q[0]) ? sfc_pkg::PART_ID : sfc_pkg::MAKER_ID;
        end
        default: oen = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (!sel_lo) begin
      // R25 select rise ends output
      sdo_oe <= 1'b0;
    end else if (sck_fall) begin
      sdo <= obyte[3'h7 - obit];
      sdo_oe <= oen;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      write_in_progress <= 1'b0;
      write_latch_armed <= 1'b0;
      asleep <= 1'b0;
    end else begin
      write_in_progress <= busy;
      write_latch_armed <= wel_q;
      asleep <= sleeping;
    end
  end

  // ==========================================================
  // checks
  a_erase_needs_latch: assert property ( // R03
    wipe_req.valid |-> $past(wel_q))
    else $error("erase without latch");
  a_array_unprot: assert property ( // R09
    wipe_req.valid && wipe_req.kind == 2'h2 |-> $past(bp) == 3'h0)
    else $error("array erase while protected");
  a_busy_follows: assert property ( // R05
    wipe_req.valid |=> write_in_progress)
    else $error("busy not shown");
  a_sleep_not_busy: assert property ( // R12
    busy && sck_rise && cnt_q == 6'h07 |=>
    drop_q || op_q == sfc_pkg::OP_READ_STATUS)
    else $error("command taken while busy");
  a_latch_clear_end: assert property ( // R06
    $fell(busy) |-> !wel_q)
    else $error("latch kept after erase");
  a_block_unprot: assert property ( // R07
    wipe_req.valid && wipe_req.kind != 2'h2 |->
    !blk_prot($past(bp), wipe_req.addr))
    else $error("protected block erased");
  a_out_off_desel: assert property ( // R25
    !sel_lo |=> !sdo_oe)
    else $error("drive after deselect");
  a_sleep_no_erase: assert property ( // R11
    sleeping |=> !wipe_req.valid)
    else $error("erase while asleep");
  c_block: cover property (wipe_req.valid && wipe_req.kind == 2'h0);
  c_array: cover property (wipe_req.valid && wipe_req.kind == 2'h2);
  c_sleep: cover property (sleeping);
  c_wake: cover property (sleeping ##1 st_q == SFC_WAIT);
endmodule

// ### tb/sfc_host.sv
/*
 * sfc_host: serial host model driving select, clock and data.
 * assumes the device shifts out after falling sclk; sclk 64 ns, idle low.
 */
`timescale 1ns/1ps
module sfc_host (
  // serial link
  output logic      sel_b,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  initial begin
    sel_b = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // ==========================================================
  // one frame: n_in bits of dat, then n_out bits back
  task automatic xfer(input logic [31:0] dat, input int n_in,
                      input int n_out, output logic [23:0] got,
                      output logic oe_ok);
    logic [31:0] sh;
    sh = dat << (32 - n_in);
    got = '0;
    oe_ok = 1'b1;
    sel_b = 1'b0;
    #40;
    for (int i = 0; i < n_in + n_out; i++) begin
      sdi = sh[31];
      sh = sh << 1;
      #32 sclk = 1'b1;
      // sampled late in the high phase: device output trails the fall
      #31;
      if (i >= n_in) begin
        // undriven line reads as the inverse of its last bit
        got = {got[22:0], sdo_oe ? sdo : ~sdo};
        oe_ok = oe_ok & sdo_oe;
      end
      #1 sclk = 1'b0;
    end
    #40 sel_b = 1'b1;
    // released line shows the inverse of its last value
    sdi = ~sdi;
    #40;
  endtask
endmodule

// ### tb/sfc_core_test.sv
/*
 * sfc_core_test: self-checking bench for the serial flash command block.
 * assumes sfc_host as the serial host and package timing constants.
 */
`timescale 1ns/1ps
module sfc_core_test;
  logic clk, rst_b, arm_write_cmd, sel_b, sclk, sdi, sdo, sdo_oe, oe_ok;
  logic write_in_progress, write_latch_armed, asleep;
  sfc_pkg::sfc_protect_t protect;
  sfc_pkg::sfc_wipe_t    wipe_req;
  logic [25:0] exp_q[$];
  logic [25:0] e;
  logic [23:0] m, got, r;
  logic [31:0] seed;
  int          errors, check_count, cyc;
  logic [31:0] id_dat[4] = '{32'h90000000, 32'h90000001, 32'h9f, 32'hab000000};
  int          id_in[4] = '{32, 32, 8, 32};
  int          id_out[4] = '{16, 16, 24, 16};

  sfc_core dut_u (.clk(clk), .rst_b(rst_b), .sel_b(sel_b), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .protect(protect),
    .arm_write_cmd(arm_write_cmd), .write_in_progress(write_in_progress),
    .write_latch_armed(write_latch_armed), .asleep(asleep),
    .wipe_req(wipe_req));
  sfc_host host_u (.sel_b(sel_b), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // helpers
  function automatic logic [23:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[23:0];
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_for(input logic which, lvl, input int lim);
    int k;
    k = 0;
    while (((which ? asleep : write_in_progress) !== lvl) && k < lim) begin
      @(posedge clk);
      k++;
    end
    check("wait level", which ? asleep : write_in_progress, lvl);
  endtask
  task automatic wipe(input logic [31:0] dat, input int n, input logic armit,
                      input logic [1:0] kind, input logic ok);
    if (armit) begin
      @(posedge clk) #1 arm_write_cmd = 1'b1;
      @(posedge clk) #1 arm_write_cmd = 1'b0;
      repeat (2) @(posedge clk);
      check("latch", write_latch_armed, 1'b1);
    end
    if (ok) exp_q.push_back({kind, dat[23:0]});
    host_u.xfer(dat, n, 0, got, oe_ok);
    if (!ok) begin
      repeat (30) @(posedge clk);
      check("no cycle", write_in_progress, 1'b0);
    end else begin
      wait_for(1'b0, 1'b1, 20);
      host_u.xfer(sfc_pkg::OP_READ_STATUS, 8, 8, got, oe_ok);
      check("status", {got[4:2], got[0]}, {protect, 1'b1});
      host_u.xfer(sfc_pkg::OP_THREE_ID, 8, 24, got, oe_ok);
      check("busy 3id", oe_ok, 1'b0);
      host_u.xfer({sfc_pkg::OP_WAKE_ID, 24'h0}, 32, 8, got, oe_ok);
      check("busy wake", oe_ok, 1'b0);
      host_u.xfer(sfc_pkg::OP_SLEEP, 8, 0, got, oe_ok);
      wait_for(1'b0, 1'b0, sfc_pkg::ARRAY_WIPE_CYC + 100);
      check("latch clr", write_latch_armed, 1'b0);
      repeat (sfc_pkg::SLEEP_ENTRY_CYC + 20) @(posedge clk);
      check("busy sleep", asleep, 1'b0);
    end
  endtask
  // ==========================================================
  // wipe request monitor against the noted expectations
  always @(posedge clk) begin
    if (rst_b === 1'b1 && wipe_req.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("stray wipe", 1'b1, 1'b0);
      end else begin
        e = exp_q.pop_front();
        m = (e[25:24] == 2'h0) ? 24'hff8000 :
            (e[25:24] == 2'h1) ? 24'hff0000 : 24'h0;
        check("wipe", {wipe_req.kind, wipe_req.addr & m},
              {e[25:24], e[23:0] & m});
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      errors++;
      close_out();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    errors = 0;
    check_count = 0;
    cyc = 0;
    seed = 32'd64090;
    rst_b = 1'b0;
    arm_write_cmd = 1'b0;
    protect = '0;
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    check("idle", {asleep, write_in_progress, write_latch_armed}, 3'h0);
    r = xs();
    wipe({sfc_pkg::OP_WIPE_32K, r}, 32, 1'b0, 2'h0, 1'b0);
    wipe({sfc_pkg::OP_WIPE_32K, r}, 32, 1'b1, 2'h0, 1'b1);
    r = xs();
    wipe({sfc_pkg::OP_WIPE_64K, r} >> 1, 31, 1'b1, 2'h1, 1'b0);
    @(posedge clk) #1 protect = 3'h1;
    wipe({sfc_pkg::OP_WIPE_64K, 8'h0f, r[15:0]}, 32, 1'b1, 2'h1, 1'b0);
    wipe({sfc_pkg::OP_WIPE_64K, 5'h0, r[18:0]}, 32, 1'b1, 2'h1, 1'b1);
    wipe(sfc_pkg::OP_ARRAY_A, 8, 1'b1, 2'h2, 1'b0);
    @(posedge clk) #1 protect = 3'h0;
    wipe({sfc_pkg::OP_ARRAY_B, 1'b0}, 9, 1'b1, 2'h2, 1'b0);
    wipe(sfc_pkg::OP_ARRAY_B, 8, 1'b1, 2'h2, 1'b1);
    for (int i = 0; i < 4; i++) begin
      host_u.xfer(id_dat[i], id_in[i], id_out[i], got, oe_ok);
      check("id", got, i == 0 ? {sfc_pkg::MAKER_ID, sfc_pkg::PART_ID} :
        i == 1 ? {sfc_pkg::PART_ID, sfc_pkg::MAKER_ID} :
        i == 2 ? {sfc_pkg::MAKER_ID, sfc_pkg::MEM_TYPE_ID,
                  sfc_pkg::CAPACITY_ID} :
        {sfc_pkg::PART_ID, sfc_pkg::PART_ID});
    end
    host_u.xfer({sfc_pkg::OP_SLEEP, 1'b0}, 9, 0, got, oe_ok);
    repeat (sfc_pkg::SLEEP_ENTRY_CYC + 20) @(posedge clk);
    check("sleep late", asleep, 1'b0);
    host_u.xfer(sfc_pkg::OP_SLEEP, 8, 0, got, oe_ok);
    repeat (10) @(posedge clk);
    check("sleep delay", asleep, 1'b0);
    wait_for(1'b1, 1'b1, sfc_pkg::SLEEP_ENTRY_CYC + 20);
    @(posedge clk) #1 arm_write_cmd = 1'b1;
    @(posedge clk) #1 arm_write_cmd = 1'b0;
    repeat (2) @(posedge clk);
    check("sleep arm", write_latch_armed, 1'b0);
    host_u.xfer(id_dat[0], 32, 16, got, oe_ok);
    check("sleep id", oe_ok, 1'b0);
    host_u.xfer(sfc_pkg::OP_WAKE_ID, 8, 0, got, oe_ok);
    wait_for(1'b1, 1'b0, sfc_pkg::WAKE_SHORT_CYC + 40);
    // a command inside the release delay must be dropped
    host_u.xfer(sfc_pkg::OP_READ_STATUS, 8, 8, got, oe_ok);
    check("wake gap", oe_ok, 1'b0);
    // select held high through the release delay
    repeat (sfc_pkg::WAKE_SHORT_CYC + 10) @(posedge clk);
    host_u.xfer(sfc_pkg::OP_READ_STATUS, 8, 8, got, oe_ok);
    check("awake", {oe_ok, got[7:0]}, 9'h100);
    // sleep again, then a mid-run reset must bring standby back
    host_u.xfer(sfc_pkg::OP_SLEEP, 8, 0, got, oe_ok);
    wait_for(1'b1, 1'b1, sfc_pkg::SLEEP_ENTRY_CYC + 20);
    @(posedge clk) #1 rst_b = 1'b0;
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    check("reset idle", {asleep, write_in_progress, write_latch_armed}, 3'h0);
    close_out();
  end
endmodule
